// file: src/ubg_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * baud generator and line status block.
 * Assumes a 25 MHz system clock and a 3-bit register address.
 */
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define UBG_ADDR_DATA 3'h0
`define UBG_ADDR_IER 3'h1
`define UBG_ADDR_LCR 3'h3
`define UBG_ADDR_LSR 3'h5
`define UBG_ADDR_MODE 3'h7

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UBG_IER_RXDATA 0
`define UBG_IER_TX_HOLDING_EMPTY_FLAG 1
`define UBG_IER_LINE 2
`define UBG_LCR_STOP2 2
`define UBG_LCR_PEN 3
`define UBG_LCR_EVEN 4
`define UBG_LCR_STICK 5
`define UBG_LCR_BREAK 6
`define UBG_LCR_LATCH_ACCESS_SELECT 7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UBG_LSR_RESET 8'h60
`define UBG_DIV_RESET 16'h0000

// ----------------------------------------------------------------------
// timing: reference 1.8432 MHz taken from the 25 MHz clock by an
// accumulator stepping 18432 in 250000 (both scaled by 1/100)
// ----------------------------------------------------------------------
`define UBG_SYS_HZ 25000000
`define UBG_REF_HZ 1843200
`define UBG_ACC_STEP 19'd18432
`define UBG_ACC_MOD 19'd250000
`define UBG_OVERSAMPLE 16
`define UBG_MID_PHASE 4'h7
`define UBG_LAST_PHASE 4'hf
`define UBG_HALF_BIT 4'h8

`endif

// file: src/ubg_pkg.sv
/*
 * Types shared by the baud generator and line status block.
 * Assumes nothing of its surroundings.
 */
package ubg_pkg;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PAR,
        RX_STOP,
        RX_BRK
    } ubg_rx_e;

    typedef logic [7:0] ubg_byte_t;

endpackage

// file: src/ubg_top.sv
/*
 * Baud rate generator and line status logic of one serial channel, with
 * the minimal receive and transmit paths that drive the status flags.
 * Assumes a 25 MHz sys_clk, a register master that follows the plain
 * strobe protocol, and serial_in_pin synchronous to sys_clk.
 */
// What this block does
// - generator output is sixteen times baud
// - same tick clocks transmitter and receiver
// - divisor held as two byte latches
// - writing either byte reloads baud counter
// - reference 1.8432 MHz from system clock
// - data ready sets on char, clears on read
// - overrun sets on lost char, status read clears
// - parity error sets, status read clears
// - framing error on low stop bit
// - after framing error resync on low
// - break flag after character time low
// - line errors raise enabled interrupt
// - holding empty sets on transfer, write clears
// - holding empty with enable raises interrupt
// - extended mode bit6 means all empty
// - legacy mode bit6 means shifter empty
// - status bit 7 reads zero
`include "ubg_consts.svh"

module ubg_top #(
    parameter int unsigned DIV_W = 16
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic serial_in_pin,
    output logic [7:0] reg_rdata_q,
    output logic serial_out_q,
    output logic baud_out_q,
    output logic irq_q
);

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic [7:0] lcr_q;
    logic [2:0] ier_q;
    logic ext_mode_q;
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic latch_access_select;
    logic div_wr;
    logic thr_wr;
    logic rbr_rd;
    logic lsr_rd;

    assign latch_access_select = lcr_q[`UBG_LCR_LATCH_ACCESS_SELECT];
    assign div_wr = reg_wr && latch_access_select &&
        (reg_addr == `UBG_ADDR_DATA || reg_addr == `UBG_ADDR_IER);
    assign thr_wr = reg_wr && !latch_access_select && reg_addr == `UBG_ADDR_DATA;
    assign rbr_rd = reg_rd && !latch_access_select && reg_addr == `UBG_ADDR_DATA;
    assign lsr_rd = reg_rd && reg_addr == `UBG_ADDR_LSR;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lcr_q <= 8'h00;
            ier_q <= 3'h0;
            ext_mode_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `UBG_ADDR_LCR)
                lcr_q <= reg_wdata;
            if (reg_addr == `UBG_ADDR_IER && !latch_access_select)
                ier_q <= reg_wdata[2:0];
            if (reg_addr == `UBG_ADDR_MODE)
                ext_mode_q <= reg_wdata[0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_lo_q <= 8'h00;
            div_hi_q <= 8'h00;
        end
        else if (div_wr)
        begin
            if (reg_addr == `UBG_ADDR_DATA)
                div_lo_q <= reg_wdata;
            else
                div_hi_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // reference and baud generator
    // ------------------------------------------------------------------
    logic [17:0] acc_q;
    logic [18:0] acc_sum;
    logic ref_tick_q;
    logic [DIV_W-1:0] baud_cnt_q;
    logic [DIV_W-1:0] div_new;

    assign acc_sum = {1'b0, acc_q} + `UBG_ACC_STEP;

    // fractional step to the reference rate
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q <= 18'h0;
            ref_tick_q <= 1'b0;
        end
        else if (acc_sum >= `UBG_ACC_MOD)
        begin
            acc_q <= 18'(acc_sum - `UBG_ACC_MOD);
            ref_tick_q <= 1'b1;
        end
        else
        begin
            acc_q <= acc_sum[17:0];
            ref_tick_q <= 1'b0;
        end
    end

    // new divisor as it will stand once the write lands
    always_comb
    begin
        div_new = DIV_W'({div_hi_q, div_lo_q});
        if (div_wr && reg_addr == `UBG_ADDR_DATA)
            div_new = DIV_W'({div_hi_q, reg_wdata});
        else if (div_wr)
            div_new = DIV_W'({reg_wdata, div_lo_q});
    end

    // one tick per divisor reference periods
    // a zero divisor behaves as one, never stalls
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            baud_cnt_q <= DIV_W'(0);
            baud_out_q <= 1'b0;
        end
        else if (div_wr)
        begin
            baud_cnt_q <= div_new;
            baud_out_q <= 1'b0;
        end
        else if (ref_tick_q && baud_cnt_q <= DIV_W'(1))
        begin
            baud_cnt_q <= div_new;
            baud_out_q <= 1'b1;
        end
        else
        begin
            if (ref_tick_q)
                baud_cnt_q <= baud_cnt_q - DIV_W'(1);
            baud_out_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    ubg_pkg::ubg_rx_e rx_st_q;
    logic rx_in_q;
    logic [3:0] rx_ph_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_par_q;
    ubg_pkg::ubg_byte_t rx_buf_q;
    logic [7:0] brk_cnt_q;
    logic [7:0] frame_ticks;
    logic [2:0] wl_last;
    logic par_exp;
    logic ev_dr_q;
    logic ev_oe_q;
    logic ev_pe_q;
    logic ev_fe_q;
    logic ev_bi_q;
    logic dr_q;

    assign wl_last = {1'b0, lcr_q[1:0]} + 3'd4;
    // start + data + parity + stop, in sixteenth-bit ticks
    assign frame_ticks = {2'b00, {1'b0, wl_last} + 4'd3
        + {3'b000, lcr_q[`UBG_LCR_PEN]}, 2'b00} << 2;
    assign par_exp = lcr_q[`UBG_LCR_STICK] ? !lcr_q[`UBG_LCR_EVEN]
        : (rx_par_q ^ !lcr_q[`UBG_LCR_EVEN]);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rx_in_q <= 1'b1;
        else
            rx_in_q <= serial_in_pin;
    end

    // low line longer than one character
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            brk_cnt_q <= 8'h00;
        else if (rx_in_q)
            brk_cnt_q <= 8'h00;
        else if (baud_out_q && brk_cnt_q <= frame_ticks)
            brk_cnt_q <= brk_cnt_q + 8'h01;
    end

    // receiver runs on the generator tick
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_st_q <= ubg_pkg::RX_IDLE;
            rx_ph_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
            rx_buf_q <= 8'h00;
            ev_dr_q <= 1'b0;
            ev_oe_q <= 1'b0;
            ev_pe_q <= 1'b0;
            ev_fe_q <= 1'b0;
            ev_bi_q <= 1'b0;
        end
        else
        begin
            ev_dr_q <= 1'b0;
            ev_oe_q <= 1'b0;
            ev_pe_q <= 1'b0;
            ev_fe_q <= 1'b0;
            ev_bi_q <= 1'b0;
            if (baud_out_q && brk_cnt_q == frame_ticks)
            begin
                ev_bi_q <= 1'b1;
                rx_st_q <= ubg_pkg::RX_BRK;
                rx_ph_q <= 4'h0;
            end
            else if (baud_out_q)
            begin
                rx_ph_q <= rx_ph_q + 4'h1;
                unique case (rx_st_q)
                    ubg_pkg::RX_IDLE:
                    begin
                        rx_ph_q <= 4'h0;
                        if (!rx_in_q)
                            rx_st_q <= ubg_pkg::RX_START;
                    end
                    ubg_pkg::RX_START:
                        if (rx_ph_q == `UBG_MID_PHASE)
                        begin
                            rx_ph_q <= 4'h0;
                            rx_bit_q <= 3'h0;
                            rx_par_q <= 1'b0;
                            rx_st_q <= rx_in_q ? ubg_pkg::RX_IDLE
                                : ubg_pkg::RX_DATA;
                        end
                    ubg_pkg::RX_DATA:
                        if (rx_ph_q == `UBG_LAST_PHASE)
                        begin
                            rx_sh_q <= {rx_in_q, rx_sh_q[7:1]};
                            rx_par_q <= rx_par_q ^ rx_in_q;
                            rx_bit_q <= rx_bit_q + 3'h1;
                            if (rx_bit_q == wl_last)
                                rx_st_q <= lcr_q[`UBG_LCR_PEN]
                                    ? ubg_pkg::RX_PAR : ubg_pkg::RX_STOP;
                        end
                    ubg_pkg::RX_PAR:
                        if (rx_ph_q == `UBG_LAST_PHASE)
                        begin
                            ev_pe_q <= rx_in_q != par_exp;
                            rx_st_q <= ubg_pkg::RX_STOP;
                        end
                    ubg_pkg::RX_STOP:
                        if (rx_ph_q == `UBG_LAST_PHASE)
                        begin
                            rx_buf_q <= rx_sh_q >> (3'd7 - wl_last);
                            ev_dr_q <= 1'b1;
                            ev_oe_q <= dr_q && !rbr_rd;
                            ev_fe_q <= !rx_in_q;
                            // low stop taken as next start
                            // the low stop was already sampled mid-bit, so
                            // the second start sample is the very next tick
                            rx_ph_q <= rx_in_q ? 4'h0 : `UBG_MID_PHASE;
                            rx_st_q <= rx_in_q ? ubg_pkg::RX_IDLE
                                : ubg_pkg::RX_START;
                        end
                    ubg_pkg::RX_BRK:
                    begin
                        // wait for half a bit of high line
                        if (!rx_in_q)
                            rx_ph_q <= 4'h0;
                        else if (rx_ph_q == `UBG_HALF_BIT - 4'h1)
                            rx_st_q <= ubg_pkg::RX_IDLE;
                    end
                    default:
                        rx_st_q <= ubg_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    ubg_pkg::ubg_byte_t thr_q;
    logic tx_holding_empty_flag_q;
    logic tx_busy_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_ph_q;
    logic [3:0] tx_left_q;
    logic [10:0] tx_frame;
    logic [3:0] tx_bits;
    logic tx_par;
    logic [7:0] wl_mask;

    assign wl_mask = 8'hff >> (3'd7 - wl_last);
    assign tx_par = lcr_q[`UBG_LCR_STICK] ? !lcr_q[`UBG_LCR_EVEN]
        : ((^(thr_q & wl_mask)) ^ !lcr_q[`UBG_LCR_EVEN]);
    assign tx_bits = {1'b0, wl_last} + 4'd3 + {3'b000, lcr_q[`UBG_LCR_PEN]}
        + {3'b000, lcr_q[`UBG_LCR_STOP2]};

    always_comb
    begin
        tx_frame = 11'h7ff;
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (3'(i) <= wl_last)
                tx_frame[i+1] = thr_q[i];
        end
        if (lcr_q[`UBG_LCR_PEN])
            tx_frame[4'(wl_last) + 4'd2] = tx_par;
    end

    // holding empty set on transfer, cleared by write
    // transmitter runs on the generator tick
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            thr_q <= 8'h00;
            tx_holding_empty_flag_q <= 1'b1;
            tx_busy_q <= 1'b0;
            tx_sh_q <= 11'h7ff;
            tx_ph_q <= 4'h0;
            tx_left_q <= 4'h0;
        end
        else
        begin
            if (thr_wr)
            begin
                thr_q <= reg_wdata;
                tx_holding_empty_flag_q <= 1'b0;
            end
            else if (!tx_busy_q && !tx_holding_empty_flag_q)
            begin
                tx_sh_q <= tx_frame;
                tx_left_q <= tx_bits;
                tx_ph_q <= 4'h0;
                tx_busy_q <= 1'b1;
                tx_holding_empty_flag_q <= 1'b1;
            end
            if (tx_busy_q && baud_out_q)
            begin
                tx_ph_q <= tx_ph_q + 4'h1;
                if (tx_ph_q == `UBG_LAST_PHASE)
                begin
                    tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                    tx_left_q <= tx_left_q - 4'h1;
                    if (tx_left_q == 4'h1)
                        tx_busy_q <= 1'b0;
                end
            end
        end
    end

    // break control forces spacing without touching the shifter
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            serial_out_q <= 1'b1;
        else
            serial_out_q <= !lcr_q[`UBG_LCR_BREAK] &&
                (!tx_busy_q || tx_sh_q[0]);
    end

    // ------------------------------------------------------------------
    // line status flags
    // ------------------------------------------------------------------
    logic oe_q;
    logic pe_q;
    logic fe_q;
    logic bi_q;
    logic tx_all_empty_flag;
    logic [7:0] lsr_val;

    assign tx_all_empty_flag = ext_mode_q ? (tx_holding_empty_flag_q && !tx_busy_q) : !tx_busy_q;
    assign lsr_val = {1'b0, tx_all_empty_flag, tx_holding_empty_flag_q, bi_q, fe_q, pe_q, oe_q, dr_q};

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dr_q <= 1'b0;
            oe_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            bi_q <= 1'b0;
        end
        else
        begin
            dr_q <= ev_dr_q || (dr_q && !rbr_rd);
            oe_q <= ev_oe_q || (oe_q && !lsr_rd);
            pe_q <= ev_pe_q || (pe_q && !lsr_rd);
            fe_q <= ev_fe_q || (fe_q && !lsr_rd);
            bi_q <= ev_bi_q || (bi_q && !lsr_rd);
        end
    end

    // line errors gated by their enable
    // holding empty gated by its enable
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_q <= 1'b0;
        else
            irq_q <= (ier_q[`UBG_IER_LINE] && (oe_q || pe_q || fe_q || bi_q))
                || (ier_q[`UBG_IER_TX_HOLDING_EMPTY_FLAG] && tx_holding_empty_flag_q)
                || (ier_q[`UBG_IER_RXDATA] && dr_q);
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // status writes are simply ignored
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata_q <= 8'h00;
        else if (!reg_rd)
            reg_rdata_q <= 8'h00;
        else
            unique case (reg_addr)
                `UBG_ADDR_DATA: reg_rdata_q <= latch_access_select ? div_lo_q : rx_buf_q;
                `UBG_ADDR_IER: reg_rdata_q <= latch_access_select ? div_hi_q
                    : {5'h00, ier_q};
                `UBG_ADDR_LCR: reg_rdata_q <= lcr_q;
                `UBG_ADDR_LSR: reg_rdata_q <= lsr_val;
                `UBG_ADDR_MODE: reg_rdata_q <= {7'h00, ext_mode_q};
                default: reg_rdata_q <= 8'h00;
            endcase
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence lsr_read_s;
        lsr_rd && !ev_oe_q && !ev_pe_q && !ev_fe_q && !ev_bi_q;
    endsequence

    div_reload_a: assert property (
        div_wr |=> baud_cnt_q == DIV_W'({div_hi_q, div_lo_q}))
        else $error("divisor write did not reload counter");
    tick_reload_a: assert property (
        baud_out_q |-> baud_cnt_q == DIV_W'({div_hi_q, div_lo_q}))
        else $error("tick without reload");
    tick_spacing_a: assert property (
        baud_out_q && !div_wr && div_lo_q == 8'h02 && div_hi_q == 8'h00
        |=> !baud_out_q [*8])
        else $error("ticks closer than divisor allows");
    dr_set_a: assert property (
        ev_dr_q |=> dr_q)
        else $error("ready flag missed a character");
    dr_clear_a: assert property (
        rbr_rd && !ev_dr_q |=> !dr_q)
        else $error("ready flag not cleared by read");
    err_clear_a: assert property (
        lsr_read_s |=> !oe_q && !pe_q && !fe_q && !bi_q)
        else $error("error flags survived status read");
    fe_set_a: assert property (
        ev_fe_q |=> fe_q && rx_st_q == ubg_pkg::RX_START)
        else $error("framing error without resync");
    tx_holding_empty_flag_clear_a: assert property (
        thr_wr |=> !tx_holding_empty_flag_q)
        else $error("holding empty not cleared by write");
    tx_holding_empty_flag_irq_a: assert property (
        tx_holding_empty_flag_q && ier_q[`UBG_IER_TX_HOLDING_EMPTY_FLAG] |=> irq_q)
        else $error("holding empty interrupt missing");
    tx_all_empty_flag_ext_a: assert property (
        ext_mode_q && !tx_holding_empty_flag_q |-> !tx_all_empty_flag)
        else $error("empty flag set with holding full");
    bit7_zero_a: assert property (
        $past(lsr_rd) |-> !reg_rdata_q[7])
        else $error("status bit 7 read as one");

endmodule // ubg_top

// file: bench/ubg_remote_dev.sv
/*
 * Remote serial sender model that drives the receive line of the block.
 * Assumes the block's 16x tick paces its bits, so bit edges line up.
 */
module ubg_remote_dev (
    input wire logic sys_clk,
    input wire logic tick,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // line driving
    // ------------------------------------------------------------------
    initial line = 1'b1;

    task automatic hold_bits(input logic v, input int n);
        line <= v;
        repeat (n * 16) @(posedge sys_clk iff tick);
    endtask

    // one frame, lsb first; parity even unless told to break it
    task automatic send(input logic [7:0] d, input logic par_en,
                        input logic bad_par, input logic bad_stop);
        hold_bits(1'b0, 1);
        for (int i = 0; i < 8; i++)
            hold_bits(d[i], 1);
        if (par_en)
            hold_bits(^d ^ bad_par, 1);
        hold_bits(~bad_stop, 1);
        hold_bits(1'b1, 1);
    endtask

    task automatic send_break(input int nbits);
        hold_bits(1'b0, nbits);
        hold_bits(1'b1, 2);
    endtask
endmodule // ubg_remote_dev

// file: bench/ubg_top_tb.sv
/*
 * Self-checking bench for the baud generator and line status block.
 * Assumes the remote sender model paces frames from the block's tick.
 */
module ubg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic serial_in_pin, serial_out_q, baud_out_q, irq_q;
    logic [7:0] reg_rdata_q, rd_v, b;
    int errors = 0, n_tests = 0, ticks, dv;

    ubg_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .serial_in_pin(serial_in_pin), .reg_rdata_q(reg_rdata_q),
        .serial_out_q(serial_out_q), .baud_out_q(baud_out_q),
        .irq_q(irq_q));
    ubg_remote_dev far_end (.sys_clk(sys_clk), .tick(baud_out_q),
        .line(serial_in_pin));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input string w, input logic [7:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", w, e, s);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata_q;
    endtask

    task automatic rc(input string w, input logic [2:0] a,
                      input logic [7:0] m, e);
        rd(a);
        check(w, rd_v & m, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang in a tick-paced frame ends here
    initial
    begin
        #4000000;
        errors++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h84c2));
        settle(2);
        arst_n <= 1'b1;
        rc("status reset", 3'h5, 8'hff, 8'h60);
        rc("unmapped", 3'h2, 8'hff, 8'h00);
        wr(3'h5, 8'hff);
        rc("status write", 3'h5, 8'hff, 8'h60);
        wr(3'h3, 8'h80);
        wr(3'h1, 8'h01);
        rc("div high", 3'h1, 8'hff, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            dv = (k == 0) ? 1 : (k == 1) ? 12 : 2 + $urandom % 5;
            wr(3'h1, 8'h00);
            wr(3'h0, dv[7:0]);
            rc("div low", 3'h0, 8'hff, dv[7:0]);
            ticks = 0;
            repeat (1000 * dv) @(posedge sys_clk)
                if (baud_out_q) ticks++;
            check("ticks", {7'h0, ticks >= 72 && ticks <= 75}, 8'h01);
        end
        wr(3'h0, 8'h01);
        wr(3'h3, 8'h03);
        b = $urandom;
        far_end.send(b, 1'b0, 1'b0, 1'b0);
        settle(8);
        rc("rx ready", 3'h5, 8'hff, 8'h61);
        rc("rx data", 3'h0, 8'hff, b);
        rc("rx read", 3'h5, 8'hff, 8'h60);
        far_end.send(~b, 1'b0, 1'b0, 1'b0);
        far_end.send(b, 1'b0, 1'b0, 1'b0);
        settle(8);
        rc("overrun", 3'h5, 8'hff, 8'h63);
        rc("overrun clr", 3'h5, 8'hff, 8'h61);
        rc("newest", 3'h0, 8'hff, b);
        wr(3'h3, 8'h1b);
        wr(3'h1, 8'h04);
        for (int p = 0; p < 2; p++)
        begin
            b = $urandom;
            far_end.send(b, 1'b1, p[0], 1'b0);
            settle(8);
            check("line irq", {7'h0, irq_q}, {7'h0, p[0]});
            rc("parity", 3'h5, 8'h0f, {5'h0, p[0], 2'b01});
            rc("par data", 3'h0, 8'hff, b);
            settle(3);
            check("irq drop", {7'h0, irq_q}, 8'h00);
        end
        wr(3'h3, 8'h03);
        far_end.send(8'h5a, 1'b0, 1'b0, 1'b1);
        settle(8);
        rc("frame err", 3'h5, 8'h08, 8'h08);
        settle(2600);
        rc("resync char", 3'h0, 8'hff, 8'hff);
        rd(3'h5);
        far_end.send_break(24);
        settle(8);
        rc("break", 3'h5, 8'h10, 8'h10);
        rd(3'h0);
        rc("break clr", 3'h5, 8'h1e, 8'h00);
        wr(3'h1, 8'h02);
        settle(3);
        check("tx_holding_empty_flag irq", {7'h0, irq_q}, 8'h01);
        for (int m = 1; m >= 0; m--)
        begin
            wr(3'h7, m[7:0]);
            wr(3'h0, 8'($urandom));
            rc("tx busy", 3'h5, 8'h60, 8'h20);
            check("tx start", {7'h0, serial_out_q}, 8'h00);
            for (int t = 0; t < 2000 && rd_v[6] !== 1'b1; t++)
                rd(3'h5);
            check("tx done", rd_v, 8'h60);
            check("tx idle", {7'h0, serial_out_q}, 8'h01);
        end
        wr(3'h0, 8'h00);
        rc("legacy busy", 3'h5, 8'h40, 8'h00);
        wr(3'h1, 8'h00);
        settle(3);
        check("irq off", {7'h0, irq_q}, 8'h00);
        complete_run();
    end
endmodule // ubg_top_tb
